// ===== tb_txup_path.sv
// Self-checking bench of the transmit path.
// Assumes 250 MHz core clock; zero tuning word holds carrier.
`timescale 1ns/10ps
module tb_txup_path;
   import txup_pkg::*;
   localparam int CA_ST = 48;
   logic core_clk = 1'b0, resetn = 1'b0, clk_en = 1'b1, short_mode = 1'b0;
   logic [WORD_W-1:0] iq_word;
   logic frame_sync, mclk, qlo, ca_strobe_n, ca_clk, ca_data;
   logic [1:0] prof_sel = 2'h0;
   txup_prof_s [NUM_PROF-1:0] prof_tab = '0;
   logic [3:0] fine_code = 4'hF;
   logic [SAMP_W-1:0] dac_true, dac_comp;
   txup_iq_s sym = '0, taken;
   int mismatches = 0, cmp_count = 0, cyc = 0;
   always #2 core_clk = ~core_clk;
   txup_path #(.CA_STABLE(CA_ST)) i_txup_path (.CORE_CLK_I(core_clk),
      .RESETN_I(resetn), .CLK_EN_I(clk_en), .TX_IQ_WORD_BUS_I(iq_word),
      .SYMBOL_FRAME_SYNC_I(frame_sync), .PROFILE_SEL_I(prof_sel),
      .PROFILE_TABLE_I(prof_tab), .DAC_FINE_GAIN_CODE_I(fine_code),
      .MASTER_CLK_O(mclk), .DAC_TRUE_O(dac_true), .DAC_COMP_O(dac_comp),
      .CABLE_AMP_WRITE_STROBE_N_O(ca_strobe_n), .CABLE_AMP_CLK_O(ca_clk),
      .CABLE_AMP_DATA_O(ca_data));
   txup_host_model i_txup_host_model (.clk_i(core_clk), .mclk_i(mclk),
      .sym_i(sym), .short_i(short_mode), .word_o(iq_word),
      .sync_o(frame_sync), .qlo_o(qlo), .taken_o(taken));
   task automatic give_verdict;
      $display("Compares %0d, mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : give_verdict
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         give_verdict();
      end
   end
   task automatic check(input logic [11:0] got, input logic [11:0] ev,
                        input int tol);
      int d;
      d = int'(got) - int'(ev);
      cmp_count++;
      if ($isunknown(got) || d > tol || d < -tol) begin
         mismatches++;
         $display("ERROR at %0t: got %h expected %h", $time, got, ev);
      end
   endtask : check
   // Gain table rounding needs a tolerance
   function automatic logic [11:0] exp_code(input int i, input int n);
      real r;
      r = i * 2047.0 / 2048.0 * 181.0 / 256.0 * 10.0 ** ((0.5 * n - 7.5) / 20.0);
      exp_code = 12'(2048 + $rtoi(r + (r < 0.0 ? -0.5 : 0.5)));
   endfunction : exp_code
   task automatic tick;
      @(posedge core_clk);
      #1;
   endtask : tick
   task automatic t_cable(input logic [7:0] ev, input int lo, input int hi,
                          input logic late);
      int n = 0, b = 0;
      logic [7:0] got = '0;
      logic pc = 1'b0;
      while (ca_strobe_n !== 1'b0 && n < 400) begin
         @(negedge core_clk);
         n++;
      end
      cmp_count++;
      if (n < lo || n > hi) begin
         mismatches++;
         $display("ERROR at %0t: write start %h window %h %h", $time, n, lo, hi);
      end
      while (ca_strobe_n === 1'b0 && n < 900) begin
         if (ca_clk === 1'b1 && !pc) begin
            got = {got[6:0], ca_data};
            b++;
            // A mid-send change must not cut the write
            if (late && b == 3) begin
               tick();
               prof_tab[1].ca_gain = 8'hC3;
            end
         end
         pc = ca_clk;
         @(negedge core_clk);
         n++;
      end
      check({4'h0, got}, {4'h0, ev}, 0);
   endtask : t_cable
   task automatic t_levels;
      int li[4] = '{2047, -1536, 0, 1024};
      int lq[4] = '{0, 0, 1536, -1000};
      for (int k = 0; k < 4; k++) begin
         tick();
         sym.i = 12'(li[k]);
         sym.q = 12'(lq[k]);
         fine_code = (k == 3) ? 4'h5 : 4'hF;
         repeat (300) @(negedge core_clk);
         check(dac_true, exp_code(li[k], k == 3 ? 5 : 15), 8);
      end
   endtask : t_levels
   task automatic t_fine;
      for (int n = 0; n < 16; n++) begin
         tick();
         fine_code = 4'(n);
         repeat (8) @(negedge core_clk);
         check(dac_true, exp_code(1024, n), 8);
      end
   endtask : t_fine
   task automatic t_latency;
      int k;
      tick();
      sym = '0;
      repeat (300) @(negedge core_clk);
      tick();
      sym.i = 12'h400;
      k = 0;
      while (!(qlo === 1'b1 && taken === sym) && k < 64) begin
         @(negedge core_clk);
         k++;
      end
      k = 0;
      while (dac_true === 12'h800 && k < 200) begin
         @(negedge core_clk);
         k++;
      end
      check(12'(k), 12'h077, 0);
   endtask : t_latency
   task automatic t_resync;
      logic [11:0] ev;
      ev = exp_code(1024, 15);
      repeat (300) @(negedge core_clk);
      tick();
      short_mode = 1'b1;
      repeat (16) @(negedge core_clk);
      tick();
      short_mode = 1'b0;
      for (int k = 0; k < 300; k++) begin
         @(negedge core_clk);
         if ($isunknown(dac_true) || dac_true > ev + 12'h008 ||
             dac_true < ev - 12'h008)
            break;
      end
      check(dac_true, ev, 8);
   endtask : t_resync
   task automatic t_hop;
      int k;
      logic [11:0] pre;
      tick();
      pre = dac_true;
      prof_sel = 2'h1;
      k = 0;
      while (dac_true === pre && k < 400) begin
         @(negedge core_clk);
         k++;
      end
      check(12'(k < 232), 12'h001, 0);
      t_cable(8'h5A, 180 - k, 270 - k, 1'b1);
      t_cable(8'hC3, 0, 400, 1'b0);
   endtask : t_hop
   initial begin
      prof_tab[1].ftw = 26'h040_0000;
      prof_tab[1].ca_gain = 8'h5A;
      @(negedge core_clk);
      check(dac_true, 12'h800, 0);
      check(dac_comp, 12'h7FF, 0);
      repeat (2) @(posedge core_clk);
      #1;
      resetn = 1'b1;
      t_cable(8'h00, 180, 270, 1'b0);
      t_levels();
      t_fine();
      t_latency();
      t_resync();
      t_hop();
      give_verdict();
   end
endmodule : tb_txup_path
bind txup_path txup_path_sva #(.CA_STABLE(CA_STABLE)) i_txup_path_sva (
   .CORE_CLK_I(CORE_CLK_I), .RESETN_I(RESETN_I), .PROFILE_SEL_I(PROFILE_SEL_I),
   .MASTER_CLK_O(MASTER_CLK_O), .PROFILE_TABLE_I(PROFILE_TABLE_I),
   .DAC_TRUE_O(DAC_TRUE_O), .DAC_COMP_O(DAC_COMP_O),
   .CABLE_AMP_WRITE_STROBE_N_O(CABLE_AMP_WRITE_STROBE_N_O),
   .CABLE_AMP_CLK_O(CABLE_AMP_CLK_O), .CABLE_AMP_DATA_O(CABLE_AMP_DATA_O));

// ===== txup_halfband.sv
// Half-band 2x interpolator for an I/Q pair, polyphase form.
// Assumes in_vld_i pulses are at least 2*SPACING cycles apart.
`timescale 1ns/10ps
module txup_halfband #(
   parameter int TAPS = 11,
   parameter int SPACING = 8
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic in_vld_i,
   input wire txup_pkg::txup_iq_s in_i,
   output logic out_vld_o,
   output txup_pkg::txup_iq_s out_o
);
   import txup_pkg::*;

   localparam int H = (TAPS + 1) / 4;

   txup_iq_s sr_q [2*H];
   logic go_q;
   logic [7:0] cnt_q;
   txup_iq_s odd;

   if (TAPS != 11 && TAPS != 15) begin : g_bad_taps
      $error("txup_halfband: TAPS must be 11 or 15");
   end
   if (SPACING < 2 || SPACING > 255) begin : g_bad_spacing
      $error("txup_halfband: SPACING out of range");
   end

   // Symmetric taps give linear phase
   always_comb begin
      logic signed [23:0] acc_i;
      logic signed [23:0] acc_q;
      logic signed [23:0] c;
      acc_i = '0;
      acc_q = '0;
      c = '0;
      for (int k = 1; k <= H; k++) begin
         c = 24'(hb_coef(TAPS, k));
         acc_i = acc_i + c * (24'(sr_q[H-k].i) + 24'(sr_q[H+k-1].i));
         acc_q = acc_q + c * (24'(sr_q[H-k].q) + 24'(sr_q[H+k-1].q));
      end
      odd.i = sat12(36'(acc_i >>> 7));
      odd.q = sat12(36'(acc_q >>> 7));
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int k = 0; k < 2*H; k++) begin
            sr_q[k] <= '0;
         end
      end else if (ce_i && in_vld_i) begin
         sr_q[0] <= in_i;
         for (int k = 1; k < 2*H; k++) begin
            sr_q[k] <= sr_q[k-1];
         end
      end
   end

   // Odd phase first: newest sample, so changes show earliest
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         go_q <= 1'b0;
         cnt_q <= 8'h00;
         out_vld_o <= 1'b0;
         out_o <= '0;
      end else if (ce_i) begin
         go_q <= in_vld_i;
         out_vld_o <= 1'b0;
         if (go_q) begin
            out_o <= odd;
            out_vld_o <= 1'b1;
            cnt_q <= 8'(SPACING);
         end else if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
            if (cnt_q == 8'h01) begin
               out_o <= sr_q[H-1];
               out_vld_o <= 1'b1;
            end
         end
      end
   end

endmodule : txup_halfband

// ===== txup_host_model.sv
// Host model: four words per symbol on the master clock, three when short_i is set.
// Assumes the device's core and master clocks.
`timescale 1ns/10ps
module txup_host_model (
   input wire logic clk_i,
   input wire logic mclk_i,
   input wire txup_pkg::txup_iq_s sym_i,
   input wire logic short_i,
   output logic [txup_pkg::WORD_W-1:0] word_o,
   output logic sync_o,
   output logic qlo_o,
   output txup_pkg::txup_iq_s taken_o
);
   import txup_pkg::*;
   logic mclk_q = 1'b0, cut = 1'b0;
   int idx = 3;
   txup_iq_s cur = '0;
   logic [WORD_W-1:0] w;
   initial begin
      {word_o, sync_o, qlo_o, taken_o} = '0;
   end
   // The device takes the word where the master clock rises
   always @(posedge clk_i) begin
      #1;
      qlo_o = 1'b0;
      if (mclk_i && !mclk_q) begin
         qlo_o = (idx == 3);
         taken_o = cur;
         // A cut symbol is three inverted words
         idx = (cut && idx == 2) ? 0 : (idx + 1) % 4;
         if (idx == 0) begin
            cur = sym_i;
            cut = short_i;
         end
         case (idx)
            0: w = cur.i[11:6];
            1: w = cur.i[5:0];
            2: w = cur.q[11:6];
            default: w = cur.q[5:0];
         endcase
         word_o = w ^ {WORD_W{cut}};
         sync_o = (idx == 0);
      end
      mclk_q = mclk_i;
   end
endmodule : txup_host_model

// ===== txup_path.sv
// Transmit path: assembler, half-bands, CIC, modulator,
// fine gain, DAC code and cable driver gain writer.
// Assumes host inputs are synchronous to CORE_CLK_I,
// stable at MASTER_CLK_O rising edges.
`timescale 1ns/10ps
module txup_path #(
   parameter int ALIGN_DEPTH = txup_pkg::LAT_FIRST_SYS -
                               txup_pkg::PIPE_NAT_SYS,
   parameter int CA_STABLE = txup_pkg::CA_STABLE_MCLK
) (
   input wire logic CORE_CLK_I,
   input wire logic RESETN_I,
   input wire logic CLK_EN_I,
   input wire logic [txup_pkg::WORD_W-1:0] TX_IQ_WORD_BUS_I,
   input wire logic SYMBOL_FRAME_SYNC_I,
   input wire logic [1:0] PROFILE_SEL_I,
   input wire txup_pkg::txup_prof_s [txup_pkg::NUM_PROF-1:0] PROFILE_TABLE_I,
   input wire logic [3:0] DAC_FINE_GAIN_CODE_I,
   output logic MASTER_CLK_O,
   output logic [txup_pkg::SAMP_W-1:0] DAC_TRUE_O,
   output logic [txup_pkg::SAMP_W-1:0] DAC_COMP_O,
   output logic CABLE_AMP_WRITE_STROBE_N_O,
   output logic CABLE_AMP_CLK_O,
   output logic CABLE_AMP_DATA_O
);
   import txup_pkg::*;

   if (ALIGN_DEPTH < 1) begin : g_bad_align
      $error("txup_path: ALIGN_DEPTH must be at least 1");
   end
   if (CA_STABLE < 1 || CA_STABLE > 255) begin : g_bad_stable
      $error("txup_path: CA_STABLE out of range");
   end

   logic [1:0] rst_sync_q;
   logic rst_n;
   logic [1:0] ph_q;
   logic mclk_tick;

   logic [1:0] wcnt_q;
   logic [SAMP_W-1:0] ihold_q;
   logic [WORD_W-1:0] hi_q;
   txup_iq_s asm_q;
   logic asm_vld_q;

   txup_iq_s dl_q [ALIGN_DEPTH];
   logic [ALIGN_DEPTH-1:0] dlv_q;

   logic hb1_vld;
   txup_iq_s hb1_out;
   logic hb2_vld;
   txup_iq_s hb2_out;

   logic signed [CIC_W-1:0] cz_q [2][CIC_ORDER];
   logic signed [CIC_W-1:0] cz_d [2][CIC_ORDER];
   logic signed [CIC_W-1:0] cmb [2];
   logic signed [CIC_W-1:0] cout_q [2];
   logic stuff_q;
   logic signed [CIC_W-1:0] integ_q [2][CIC_ORDER];
   logic signed [SAMP_W-1:0] cic_i;
   logic signed [SAMP_W-1:0] cic_q;

   logic [1:0] prof_q;
   logic [DDS_W-1:0] acc_q;
   logic signed [SAMP_W-1:0] car_sin;
   logic signed [SAMP_W-1:0] car_cos;
   logic signed [23:0] mi_q;
   logic signed [23:0] mq_q;
   logic signed [SAMP_W-1:0] mod_q;
   logic signed [SAMP_W-1:0] gain_q;

   txup_ca_e ca_st_q;
   logic [GAIN_W-1:0] ca_want;
   logic [GAIN_W-1:0] ca_sent_q;
   logic [GAIN_W-1:0] ca_cand_q;
   logic ca_init_q;
   logic [7:0] ca_stab_q;
   logic [3:0] ca_pc_q;

   // Two-flop reset release; assertion stays async
   always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   // Master clock is core clock over four
   always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         ph_q <= 2'h0;
      end else if (CLK_EN_I) begin
         ph_q <= ph_q + 2'h1;
      end
   end
   assign MASTER_CLK_O = ph_q[1];
   // Words are taken where MASTER_CLK_O rises
   assign mclk_tick = CLK_EN_I && (ph_q == MCLK_RISE_PH);

   // Word assembler: I high, I low, Q high, Q low
   always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         wcnt_q <= 2'h0;
         ihold_q <= '0;
         hi_q <= '0;
         asm_q <= '0;
         asm_vld_q <= 1'b0;
      end else if (CLK_EN_I) begin
         asm_vld_q <= 1'b0;
         if (mclk_tick) begin
            if (SYMBOL_FRAME_SYNC_I) begin
               // Early sync drops any half-built symbol
               hi_q <= TX_IQ_WORD_BUS_I;
               wcnt_q <= 2'h1;
            end else begin
               wcnt_q <= wcnt_q + 2'h1;
               case (wcnt_q)
                  2'h0: begin
                     hi_q <= TX_IQ_WORD_BUS_I;
                  end
                  2'h1: begin
                     ihold_q <= {hi_q, TX_IQ_WORD_BUS_I};
                  end
                  2'h2: begin
                     hi_q <= TX_IQ_WORD_BUS_I;
                  end
                  default: begin
                     // Pair leaves once per four words
                     asm_q.i <= ihold_q;
                     asm_q.q <= {hi_q, TX_IQ_WORD_BUS_I};
                     asm_vld_q <= 1'b1;
                  end
               endcase
            end
         end
      end
   end

   // Pads to the fixed input-to-DAC latency
   always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         dlv_q <= '0;
         for (int k = 0; k < ALIGN_DEPTH; k++) begin
            dl_q[k] <= '0;
         end
      end else if (CLK_EN_I) begin
         dl_q[0] <= asm_q;
         dlv_q[0] <= asm_vld_q;
         for (int k = 1; k < ALIGN_DEPTH; k++) begin
            dl_q[k] <= dl_q[k-1];
            dlv_q[k] <= dlv_q[k-1];
         end
      end
   end

   // Two half-band stages, 11 plus 15 taps
   txup_halfband #(
      .TAPS(HB1_TAPS),
      .SPACING(HB1_SPACING)
   ) u_halfband_stage_one (
      .clk_i(CORE_CLK_I),
      .rst_n_i(rst_n),
      .ce_i(CLK_EN_I),
      .in_vld_i(dlv_q[ALIGN_DEPTH-1]),
      .in_i(dl_q[ALIGN_DEPTH-1]),
      .out_vld_o(hb1_vld),
      .out_o(hb1_out)
   );

   txup_halfband #(
      .TAPS(HB2_TAPS),
      .SPACING(HB2_SPACING)
   ) u_halfband_stage_two (
      .clk_i(CORE_CLK_I),
      .rst_n_i(rst_n),
      .ce_i(CLK_EN_I),
      .in_vld_i(hb1_vld),
      .in_i(hb1_out),
      .out_vld_o(hb2_vld),
      .out_o(hb2_out)
   );

   // CIC combs run at the low rate
   always_comb begin
      logic signed [CIC_W-1:0] c;
      c = '0;
      for (int ch = 0; ch < 2; ch++) begin
         c = (ch == 0) ? CIC_W'(hb2_out.i) : CIC_W'(hb2_out.q);
         for (int s = 0; s < CIC_ORDER; s++) begin
            cz_d[ch][s] = c;
            c = c - cz_q[ch][s];
         end
         cmb[ch] = c;
      end
   end

   always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         stuff_q <= 1'b0;
         for (int ch = 0; ch < 2; ch++) begin
            cout_q[ch] <= '0;
            for (int s = 0; s < CIC_ORDER; s++) begin
               cz_q[ch][s] <= '0;
            end
         end
      end else if (CLK_EN_I) begin
         stuff_q <= hb2_vld;
         if (hb2_vld) begin
            cz_q <= cz_d;
            cout_q <= cmb;
         end
      end
   end

   // Integrators run every cycle on the zero-stuffed comb output;
   // wrap-around is harmless here, the combs cancel it
   always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         for (int ch = 0; ch < 2; ch++) begin
            for (int s = 0; s < CIC_ORDER; s++) begin
               integ_q[ch][s] <= '0;
            end
         end
      end else if (CLK_EN_I) begin
         for (int ch = 0; ch < 2; ch++) begin
            integ_q[ch][0] <= integ_q[ch][0] + (stuff_q ? cout_q[ch] : '0);
            for (int s = 1; s < CIC_ORDER; s++) begin
               integ_q[ch][s] <= integ_q[ch][s] + integ_q[ch][s-1];
            end
         end
      end
   end

   // Stuffing gain of 16 removed: one right shift by CIC_SHIFT = 4
   assign cic_i = sat12(36'(integ_q[0][CIC_ORDER-1] >>> CIC_SHIFT));
   assign cic_q = sat12(36'(integ_q[1][CIC_ORDER-1] >>> CIC_SHIFT));

   // Profile tuning word steers the accumulator at once
   always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         prof_q <= 2'h0;
         acc_q <= '0;
      end else if (CLK_EN_I) begin
         prof_q <= PROFILE_SEL_I;
         acc_q <= acc_q + PROFILE_TABLE_I[prof_q].ftw;
      end
   end
   assign car_sin = sin_lut(acc_q[DDS_W-1 -: 5]);
   assign car_cos = sin_lut(acc_q[DDS_W-1 -: 5] + 5'h08);

   // Modulator and fixed -3 dB scale; scaling before saturation keeps
   // full-scale I and Q from clipping
   always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         mi_q <= '0;
         mq_q <= '0;
         mod_q <= '0;
      end else if (CLK_EN_I) begin
         mi_q <= 24'(cic_i) * 24'(car_cos);
         mq_q <= 24'(cic_q) * 24'(car_sin);
         mod_q <= sat12(36'((36'(mi_q) - 36'(mq_q)) * 36'(MOD_SCALE)
                            >>> MOD_SHIFT));
      end
   end

   // Fine gain and DAC code, new every cycle
   always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         gain_q <= '0;
         DAC_TRUE_O <= 12'h800;
         DAC_COMP_O <= 12'h7FF;
      end else if (CLK_EN_I) begin
         gain_q <= sat12(36'(36'(mod_q) *
                    36'(signed'({1'b0, gain_lut(DAC_FINE_GAIN_CODE_I)}))
                             >>> FINE_SHIFT));
         DAC_TRUE_O <= {~gain_q[SAMP_W-1], gain_q[SAMP_W-2:0]};
         DAC_COMP_O <= ~{~gain_q[SAMP_W-1], gain_q[SAMP_W-2:0]};
      end
   end

   // Cable driver gain writer
   assign ca_want = PROFILE_TABLE_I[prof_q].ca_gain;

   always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         ca_st_q <= CA_IDLE;
         ca_sent_q <= CA_GAIN_RST;
         ca_cand_q <= CA_GAIN_RST;
         ca_init_q <= 1'b1;
         ca_stab_q <= 8'h00;
         ca_pc_q <= 4'h0;
      end else if (CLK_EN_I) begin
         case (ca_st_q)
            CA_IDLE: begin
               // Reset forces one write of the selected profile's gain
               if (ca_want != ca_sent_q || ca_init_q) begin
                  ca_cand_q <= ca_want;
                  ca_stab_q <= 8'h00;
                  ca_st_q <= CA_WAIT;
               end
            end
            CA_WAIT: begin
               if (mclk_tick) begin
                  if (ca_want != ca_cand_q) begin
                     ca_cand_q <= ca_want;
                     ca_stab_q <= 8'h00;
                     if (ca_want == ca_sent_q && !ca_init_q) begin
                        ca_st_q <= CA_IDLE;
                     end
                  end else if (ca_stab_q == 8'(CA_STABLE - 1)) begin
                     ca_pc_q <= 4'h0;
                     ca_st_q <= CA_SEND;
                  end else begin
                     ca_stab_q <= ca_stab_q + 8'h01;
                  end
               end
            end
            CA_SEND: begin
               // Changes wait until the last bit is out
               if (mclk_tick) begin
                  ca_pc_q <= ca_pc_q + 4'h1;
                  if (ca_pc_q == CA_LAST_PHASE) begin
                     ca_sent_q <= ca_cand_q;
                     ca_init_q <= 1'b0;
                     ca_st_q <= CA_IDLE;
                  end
               end
            end
            default: begin
               ca_st_q <= CA_IDLE;
            end
         endcase
      end
   end

   // Two master cycles a bit, MSB first, data set with clock low
   assign CABLE_AMP_WRITE_STROBE_N_O = (ca_st_q != CA_SEND);
   assign CABLE_AMP_CLK_O = (ca_st_q == CA_SEND) && ca_pc_q[0];
   assign CABLE_AMP_DATA_O = (ca_st_q == CA_SEND) &&
                             ca_cand_q[3'h7 - ca_pc_q[3:1]];

endmodule : txup_path

// ===== txup_path_sva.sv
// Port checks of the transmit path: master clock, DAC pair, cable write.
// Assumes a bind onto txup_path.
`timescale 1ns/10ps
module txup_path_sva
   import txup_pkg::*;
#(
   parameter int CA_STABLE = txup_pkg::CA_STABLE_MCLK
) (
   input wire logic CORE_CLK_I,
   input wire logic RESETN_I,
   input wire logic [1:0] PROFILE_SEL_I,
   input wire txup_pkg::txup_prof_s [txup_pkg::NUM_PROF-1:0] PROFILE_TABLE_I,
   input wire logic MASTER_CLK_O,
   input wire logic [txup_pkg::SAMP_W-1:0] DAC_TRUE_O,
   input wire logic [txup_pkg::SAMP_W-1:0] DAC_COMP_O,
   input wire logic CABLE_AMP_WRITE_STROBE_N_O,
   input wire logic CABLE_AMP_CLK_O,
   input wire logic CABLE_AMP_DATA_O
);
   logic [GAIN_W-1:0] gain_q;
   logic ca_clk_q;
   int lo_cnt, hi_cnt, bit_cnt, stab_cnt;
   wire logic [GAIN_W-1:0] sel_gain = PROFILE_TABLE_I[PROFILE_SEL_I].ca_gain;
   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (!RESETN_I);
   // hi_cnt and stab_cnt saturate so long idle cannot wrap them
   always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         {gain_q, ca_clk_q, lo_cnt, hi_cnt, bit_cnt, stab_cnt} <= '0;
      end else begin
         gain_q <= sel_gain;
         ca_clk_q <= CABLE_AMP_CLK_O;
         lo_cnt <= CABLE_AMP_WRITE_STROBE_N_O ? 0 : lo_cnt + 1;
         hi_cnt <= !CABLE_AMP_WRITE_STROBE_N_O ? 0 : hi_cnt + (hi_cnt < 4000);
         stab_cnt <= (sel_gain != gain_q) ? 0 : stab_cnt + (stab_cnt < 4000);
         if (CABLE_AMP_WRITE_STROBE_N_O)
            bit_cnt <= 0;
         else if (CABLE_AMP_CLK_O && !ca_clk_q)
            bit_cnt <= bit_cnt + 1;
      end
   end
   a_comp_inverse: assert property (DAC_COMP_O == ~DAC_TRUE_O)
      else $error("complement output wrong");
   a_mclk_quarter: assert property ($rose(MASTER_CLK_O) |=> MASTER_CLK_O
      ##1 !MASTER_CLK_O [*2] ##1 MASTER_CLK_O)
      else $error("master clock not core over four");
   a_strobe_len: assert property ($rose(CABLE_AMP_WRITE_STROBE_N_O)
      |-> lo_cnt == 64) else $error("cable write strobe length wrong");
   a_bit_count: assert property ($rose(CABLE_AMP_WRITE_STROBE_N_O)
      |-> bit_cnt == 8) else $error("cable write not eight bits");
   a_idle_quiet: assert property (CABLE_AMP_WRITE_STROBE_N_O
      |-> !CABLE_AMP_CLK_O && !CABLE_AMP_DATA_O)
      else $error("cable lines active outside a write");
   a_ca_clk_rate: assert property ($rose(CABLE_AMP_CLK_O)
      |-> CABLE_AMP_CLK_O [*4] ##1 !CABLE_AMP_CLK_O)
      else $error("cable clock high phase wrong");
   a_data_hold: assert property ($rose(CABLE_AMP_CLK_O)
      |-> $stable(CABLE_AMP_DATA_O) && !CABLE_AMP_WRITE_STROBE_N_O)
      else $error("cable data moved at clock rise");
   a_gain_settled: assert property ($fell(CABLE_AMP_WRITE_STROBE_N_O)
      && hi_cnt > 4 * CA_STABLE + 8 |-> stab_cnt >= 4 * CA_STABLE - 4)
      else $error("cable write before stable gain");
   c_write_done: cover property ($rose(CABLE_AMP_WRITE_STROBE_N_O));
   c_dac_moves: cover property (DAC_TRUE_O != $past(DAC_TRUE_O));
   c_profile_hop: cover property ($changed(PROFILE_SEL_I));
endmodule : txup_path_sva

// ===== txup_pkg.sv
// Types, constants and helpers of the transmit upconverter.
// Assumes one 250 MHz core clock; master clock derived from it.
// Operation
// - Device drives master clock, samples word each rise
// - Sync high marks first word of symbol
// - Word order: I high, I low, Q high, Q low
// - Word pairs form signed 12-bit components
// - One I/Q pair per four master cycles
// - Two half-band stages, 26 taps, rate times four
// - Third-order CIC, rate times four, normalised gain
// - Output is I cosine minus Q sine
// - Fixed -3 dB scaling prevents modulator overflow
// - System clock is four times master clock
// - First output change 119 system cycles after input
// - Constant input settles within 176 system cycles
// - Profile change retunes carrier within 232 cycles
// - 12-bit converter, true and complement, every cycle
// - Fine gain code scales output in 0.5 dB
// - Cable driver gain from selected profile, three wires
// - Change of the selected gain, by table or profile change, triggers write
// - Write after 48-64 stable master cycles, completes
package txup_pkg;

   localparam int WORD_W = 6;
   localparam int SAMP_W = 12;
   localparam int DDS_W = 26;
   localparam int GAIN_W = 8;
   localparam int NUM_PROF = 4;
   localparam int MCLK_DIV = 4;
   localparam logic [1:0] MCLK_RISE_PH = 2'h1;
   localparam int HB1_TAPS = 11;
   localparam int HB2_TAPS = 15;
   localparam int HB1_SPACING = 8;
   localparam int HB2_SPACING = 4;
   localparam int CIC_ORDER = 3;
   localparam int CIC_W = 20;
   localparam int CIC_SHIFT = 4;
   localparam logic signed [10:0] MOD_SCALE = 11'sh0B5;
   localparam int MOD_SHIFT = 19;
   localparam int FINE_SHIFT = 10;
   localparam int LAT_FIRST_SYS = 119;
   localparam int SETTLE_SYS = 176;
   localparam int HOP_MAX_SYS = 232;
   localparam int PIPE_NAT_SYS = 12;
   localparam int CA_STABLE_MCLK = 48;
   localparam int CA_STABLE_MAX_MCLK = 64;
   localparam logic [3:0] CA_LAST_PHASE = 4'hF;
   localparam logic [GAIN_W-1:0] CA_GAIN_RST = 8'h00;

   typedef struct packed {
      logic signed [SAMP_W-1:0] i;
      logic signed [SAMP_W-1:0] q;
   } txup_iq_s;

   typedef struct packed {
      logic [DDS_W-1:0] ftw;
      logic [GAIN_W-1:0] ca_gain;
   } txup_prof_s;

   typedef enum logic [2:0] {
      CA_IDLE = 3'h1,
      CA_WAIT = 3'h2,
      CA_SEND = 3'h4
   } txup_ca_e;

   function automatic logic signed [11:0] sat12(input logic signed [35:0] x);
      if (x > 36'sh0_0000_07FF) begin
         sat12 = 12'sh7FF;
      end else if (x < -36'sh0_0000_0800) begin
         sat12 = 12'sh800;
      end else begin
         sat12 = x[11:0];
      end
   endfunction : sat12

   // Odd-phase taps over 128; even phase is a copy
   function automatic logic signed [7:0] hb_coef(input int taps, input int k);
      hb_coef = 8'sh00;
      if (taps == 11) begin
         case (k)
            1: hb_coef = 8'sh4B;
            2: hb_coef = -8'sh0E;
            3: hb_coef = 8'sh03;
            default: hb_coef = 8'sh00;
         endcase
      end else begin
         case (k)
            1: hb_coef = 8'sh4F;
            2: hb_coef = -8'sh13;
            3: hb_coef = 8'sh05;
            4: hb_coef = -8'sh01;
            default: hb_coef = 8'sh00;
         endcase
      end
   endfunction : hb_coef

   function automatic logic signed [11:0] qsin(input logic [3:0] k);
      case (k)
         4'h0: qsin = 12'sh000;
         4'h1: qsin = 12'sh18F;
         4'h2: qsin = 12'sh30F;
         4'h3: qsin = 12'sh471;
         4'h4: qsin = 12'sh5A7;
         4'h5: qsin = 12'sh6A6;
         4'h6: qsin = 12'sh763;
         4'h7: qsin = 12'sh7D8;
         default: qsin = 12'sh7FF;
      endcase
   endfunction : qsin

   // 32-point sine by quarter-wave folding
   function automatic logic signed [11:0] sin_lut(input logic [4:0] p);
      logic [3:0] off;
      off = {1'b0, p[2:0]};
      if (p[3]) begin
         off = 4'h8 - off;
      end
      sin_lut = p[4] ? -qsin(off) : qsin(off);
   endfunction : sin_lut

   // 1024 * 10^((-7.5 + 0.5 n) / 20)
   function automatic logic [10:0] gain_lut(input logic [3:0] n);
      case (n)
         4'h0: gain_lut = 11'h1B0;
         4'h1: gain_lut = 11'h1C9;
         4'h2: gain_lut = 11'h1E5;
         4'h3: gain_lut = 11'h201;
         4'h4: gain_lut = 11'h220;
         4'h5: gain_lut = 11'h240;
         4'h6: gain_lut = 11'h262;
         4'h7: gain_lut = 11'h286;
         4'h8: gain_lut = 11'h2AC;
         4'h9: gain_lut = 11'h2D5;
         4'hA: gain_lut = 11'h300;
         4'hB: gain_lut = 11'h32D;
         4'hC: gain_lut = 11'h35E;
         4'hD: gain_lut = 11'h391;
         4'hE: gain_lut = 11'h3C7;
         default: gain_lut = 11'h400;
      endcase
   endfunction : gain_lut

endpackage : txup_pkg
